//--- core/pmu_cru_pkg.sv
package pmu_cru_pkg;
  // ---------------------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------------------
  localparam logic [15:0] pll_ctrl0_offset       = 16'hc000;
  localparam logic [15:0] pll_ctrl1_offset       = 16'hc004;
  localparam logic [15:0] pll_ctrl2_offset       = 16'hc008;
  localparam logic [15:0] clock_gate_ctrl0_offset = 16'hc080;
  localparam logic [15:0] clock_gate_ctrl1_offset = 16'hc084;
  localparam logic [15:0] lock_threshold_offset  = 16'hc0a0;
  localparam logic [15:0] reset_key_one_offset   = 16'hc0b0;
  localparam logic [15:0] reset_key_two_offset   = 16'hc0b4;
  localparam logic [15:0] reset_hold_offset      = 16'hc0b8;
  localparam logic [15:0] divider_ctrl_offset    = 16'hc0c0;
  // ---------------------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int          mask_shift             = 16;
  localparam int          bypass_bit             = 15;
  localparam int          div_one_msb            = 14;
  localparam int          div_one_lsb            = 12;
  localparam int          feedback_msb           = 11;
  localparam int          powerdown_select_bit   = 15;
  localparam int          powerdown_one_bit      = 14;
  localparam int          powerdown_zero_bit     = 13;
  localparam int          modulator_off_bit      = 12;
  localparam int          lock_bit               = 10;
  localparam int          div_two_msb            = 8;
  localparam int          div_two_lsb            = 6;
  localparam int          ref_div_msb            = 5;
  localparam logic [15:0] pll_ctrl0_reset        = 16'h1000;
  localparam logic [15:0] pll_ctrl1_reset        = 16'h1041;
  localparam logic [15:0] gate0_writable         = 16'hf1ff;
  localparam logic [15:0] gate1_writable         = 16'h071f;
  localparam logic [15:0] key_one_value          = 16'hfdb9;
  localparam logic [15:0] key_two_value          = 16'heca8;
  localparam logic [15:0] lock_threshold_reset   = 16'h0100;
  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int          clock_mhz              = 40;
  localparam int          pll_reset_hold_ns      = 1000;
  localparam int          pll_reset_cycles       = (pll_reset_hold_ns * clock_mhz) / 1000 + 1;
  localparam int          lock_wait_cycles       = 1500;
  localparam int          settle_us              = 138;
  localparam int          settle_cycles          = settle_us * clock_mhz;
  localparam int          output_wait_cycles     = 768;
  localparam int          deglitch_cycles        = 4;
  localparam int          max_lock_delay         = 500;
  localparam int          slip_count_cycles      = 256;
  localparam int          reset_hold_max_us      = 1000;
  localparam int          reset_hold_max_cycles  = reset_hold_max_us * clock_mhz;
  // ---------------------------------------------------------------------------
  // sequencer states, gray along the path
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    seq_filter  = 3'b000,
    seq_pll_rst = 3'b001,
    seq_lock    = 3'b011,
    seq_settle  = 3'b010,
    seq_clocks  = 3'b110,
    seq_run     = 3'b111
  } seq_state_type;
endpackage : pmu_cru_pkg

//--- core/pmu_clock_divider.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// half duty and half step divider, both edges of source
// ---------------------------------------------------------------------------
module pmu_clock_divider (
  input  wire logic       i_clock,
  input  wire logic       i_resetn,
  input  wire logic [4:0] i_div_value,
  output logic            o_half_duty,
  output logic            o_half_step
);
  logic [5:0] rise_cnt_q;
  logic [5:0] rise_cnt_d;
  logic [5:0] step_cnt_q;
  logic [5:0] step_cnt_d;
  logic       rise_out_q;
  logic       rise_out_d;
  logic       fall_out_q;
  logic       step_q;
  logic       step_d;
  logic       fall_step_q;
  logic [5:0] divisor;
  logic [5:0] step_div;

  assign divisor  = {1'b0, i_div_value} + 6'h01;
  assign step_div = {i_div_value, 1'b0} + 6'h01;

  always_comb begin
    rise_cnt_d = (rise_cnt_q + 6'h01 >= divisor) ? 6'h00 : rise_cnt_q + 6'h01;
    rise_out_d = rise_cnt_d < (divisor >> 1);
    // two output periods per 2n+1 source periods
    step_cnt_d = (step_cnt_q + 6'h01 >= step_div) ? 6'h00 : step_cnt_q + 6'h01;
    step_d     = (step_cnt_d == 6'h00);
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rise_cnt_q <= 6'h00;
      step_cnt_q <= 6'h00;
      rise_out_q <= 1'b0;
      step_q     <= 1'b0;
    end else begin
      rise_cnt_q <= rise_cnt_d;
      step_cnt_q <= step_cnt_d;
      rise_out_q <= rise_out_d;
      step_q     <= step_d;
    end
  end

  // falling edge copy stretches odd divisors by half a source period
  always_ff @(negedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      fall_step_q <= 1'b0;
      fall_out_q  <= 1'b0;
    end else begin
      // second pulse starts n and a half periods after the first
      fall_step_q <= (step_cnt_q == {1'b0, i_div_value});
      fall_out_q  <= rise_out_q;
    end
  end

  assign o_half_duty = divisor[0] ? (rise_out_q | fall_out_q) : rise_out_q;
  assign o_half_step = step_q | fall_step_q;
endmodule : pmu_clock_divider

//--- core/pmu_clock_reset_unit.sv
`timescale 1ns/1ps
//
// Function
// - gate bit one stops its clock, zero runs it; gates reset to zero
// - write to the two pll control and two gate registers changes bit n only when mask bit n+16 is set
// - deglitch external active-low power-on reset into system reset
// - hold pll reset asserted longer than one microsecond
// - allow 1500 reference cycles for lock after pll reset release
// - wait about 138 us then release chip reset for output clocks
// - count 768 cycles then release the ip pre-reset
// - modulator disabled means integer mode, vco from ref, feedback, post dividers
// - modulator enabled adds 24-bit fraction over 2^24 to feedback
// - power down forces both loop outputs low
// - bypass routes reference to divided output; software avoids toggling it
// - divider settings may change while the loop runs
// - lock bit reads one only when analog and counter lock both high
// - lock indication delayed by at most 500 reference cycles
// - lock counter counts 256 divided-reference cycles after last slip
// - half duty divider gives 50 percent duty for odd divisors
// - half step divider divides by (2n+1)/2
// - keys 0xfdb9 and 0xeca8 assert first and second global resets
// - global resets self release after a programmable hold up to 1 ms
// - first reset hits everything, second spares register files and gpio
// - power down source select picks dedicated request or change-triggered
// - pll control field layout in the two control registers
//
module pmu_clock_reset_unit
  import pmu_cru_pkg::*;
#(
  parameter int settle_count     = pmu_cru_pkg::settle_cycles,
  parameter int hold_limit       = pmu_cru_pkg::reset_hold_max_cycles
) (
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_power_on_resetn,
  input  wire logic [15:0] i_address,
  input  wire logic [31:0] i_write_data,
  input  wire logic        i_write,
  input  wire logic        i_read,
  input  wire logic        i_analog_lock,
  input  wire logic        i_cycle_slip,
  input  wire logic [31:0] i_source_clocks,
  output logic [31:0]      o_read_data,
  output logic [31:0]      o_gated_clocks,
  output logic             o_pll_resetn,
  output logic             o_chip_resetn,
  output logic             o_pre_resetn,
  output logic             o_loop_power_down,
  output logic             o_bypass,
  output logic             o_modulator_off,
  output logic [2:0]       o_output_divider_one,
  output logic [2:0]       o_output_divider_two,
  output logic [5:0]       o_reference_divider,
  output logic [11:0]      o_feedback_divider,
  output logic [23:0]      o_fraction,
  output logic             o_global_resetn_one,
  output logic             o_global_resetn_two,
  output logic             o_register_file_resetn,
  output logic             o_half_duty_clock,
  output logic             o_half_step_clock
);
  import pmu_cru_pkg::*;

  // ---------------------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------------------
  logic [15:0] pll0_q, pll0_d, pll1_q, pll1_d, gate0_q, gate0_d, gate1_q, gate1_d;
  logic [23:0] frac_q, frac_d;
  logic [15:0] thresh_q, thresh_d;
  logic [15:0] hold_q, hold_d;
  logic [4:0]  divcfg_q, divcfg_d;
  logic [31:0] rdata_q, rdata_d;
  logic        lock_status;
  logic        key_one_hit, key_two_hit;

  function automatic logic [15:0] masked(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [15:0] writable);
    masked = (old & ~(wd[31:16] & writable)) | (wd[15:0] & wd[31:16] & writable);
  endfunction : masked

  assign key_one_hit = i_write && i_address == reset_key_one_offset && i_write_data[15:0] == key_one_value;
  assign key_two_hit = i_write && i_address == reset_key_two_offset && i_write_data[15:0] == key_two_value;

  always_comb begin
    pll0_d   = pll0_q;
    pll1_d   = pll1_q;
    gate0_d  = gate0_q;
    gate1_d  = gate1_q;
    frac_d   = frac_q;
    thresh_d = thresh_q;
    hold_d   = hold_q;
    divcfg_d = divcfg_q;
    if (i_write) begin
      unique case (i_address)
        pll_ctrl0_offset:        pll0_d   = masked(pll0_q, i_write_data, 16'hffff);
        pll_ctrl1_offset:        pll1_d   = masked(pll1_q, i_write_data, 16'hf1ff);
        pll_ctrl2_offset:        frac_d   = i_write_data[23:0];
        clock_gate_ctrl0_offset: gate0_d  = masked(gate0_q, i_write_data, gate0_writable);
        clock_gate_ctrl1_offset: gate1_d  = masked(gate1_q, i_write_data, gate1_writable);
        lock_threshold_offset:   thresh_d = i_write_data[31:16];
        reset_hold_offset:       hold_d   = i_write_data[15:0];
        divider_ctrl_offset:     divcfg_d = i_write_data[4:0];
        default:                 ;
      endcase
    end
    rdata_d = 32'h0000_0000;
    if (i_read) begin
      unique case (i_address)
        pll_ctrl0_offset:        rdata_d = {16'h0000, pll0_q};
        pll_ctrl1_offset:        rdata_d = {16'h0000, pll1_q[15:11], lock_status, pll1_q[9:0]};
        pll_ctrl2_offset:        rdata_d = {8'h00, frac_q};
        clock_gate_ctrl0_offset: rdata_d = {16'h0000, gate0_q};
        clock_gate_ctrl1_offset: rdata_d = {16'h0000, gate1_q};
        lock_threshold_offset:   rdata_d = {thresh_q, 16'h0000};
        reset_hold_offset:       rdata_d = {16'h0000, hold_q};
        divider_ctrl_offset:     rdata_d = {27'h000_0000, divcfg_q};
        default:                 rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      pll0_q   <= pll_ctrl0_reset;
      pll1_q   <= pll_ctrl1_reset;
      gate0_q  <= 16'h0000;
      gate1_q  <= 16'h0000;
      frac_q   <= 24'h00_0000;
      thresh_q <= lock_threshold_reset;
      hold_q   <= 16'h0010;
      divcfg_q <= 5'h01;
      rdata_q  <= 32'h0000_0000;
    end else begin
      pll0_q   <= pll0_d;
      pll1_q   <= pll1_d;
      gate0_q  <= gate0_d;
      gate1_q  <= gate1_d;
      frac_q   <= frac_d;
      thresh_q <= thresh_d;
      hold_q   <= hold_d;
      divcfg_q <= divcfg_d;
      rdata_q  <= rdata_d;
    end
  end
  assign o_read_data = rdata_q;

  // ---------------------------------------------------------------------------
  // pll control outputs
  // ---------------------------------------------------------------------------
  logic change_pd_q, change_pd_d;
  logic div_change;
  assign div_change = i_write && ((i_address == pll_ctrl2_offset) ||
                      (i_address == pll_ctrl0_offset && i_write_data[27:16] != 12'h000) ||
                      (i_address == pll_ctrl1_offset && i_write_data[21:16] != 6'h00));
  always_comb begin
    change_pd_d = pll1_q[powerdown_select_bit] ? 1'b0 : div_change;
  end
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) change_pd_q <= 1'b0;
    else           change_pd_q <= change_pd_d;
  end

  assign o_loop_power_down    = pll1_q[powerdown_select_bit] ? pll1_q[powerdown_one_bit]
                                : (pll1_q[powerdown_zero_bit] | change_pd_q);
  assign o_bypass             = pll0_q[bypass_bit];
  assign o_modulator_off      = pll1_q[modulator_off_bit];
  assign o_output_divider_one = pll0_q[div_one_msb:div_one_lsb];
  assign o_output_divider_two = pll1_q[div_two_msb:div_two_lsb];
  assign o_reference_divider  = pll1_q[ref_div_msb:0];
  assign o_feedback_divider   = pll0_q[feedback_msb:0];
  assign o_fraction           = frac_q;

  // ---------------------------------------------------------------------------
  // lock qualification counter
  // ---------------------------------------------------------------------------
  logic [15:0] lock_cnt_q, lock_cnt_d;
  always_comb begin
    if (i_cycle_slip || !i_analog_lock || o_loop_power_down) lock_cnt_d = 16'h0000;
    else if (lock_cnt_q != thresh_q)                         lock_cnt_d = lock_cnt_q + 16'h0001;
    else                                                     lock_cnt_d = lock_cnt_q;
  end
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) lock_cnt_q <= 16'h0000;
    else           lock_cnt_q <= lock_cnt_d;
  end
  assign lock_status = i_analog_lock && (lock_cnt_q == thresh_q);

  // ---------------------------------------------------------------------------
  // power-on sequencer
  // ---------------------------------------------------------------------------
  seq_state_type state_q, state_d;
  logic [15:0]   seq_cnt_q, seq_cnt_d;
  logic [2:0]    filt_q, filt_d;
  logic          por_s1_q, por_s2_q;

  always_comb begin
    filt_d = por_s2_q ? ((filt_q == 3'(deglitch_cycles)) ? filt_q : filt_q + 3'h1) : 3'h0;
    state_d   = state_q;
    seq_cnt_d = seq_cnt_q + 16'h0001;
    unique case (state_q)
      seq_filter:  if (filt_q == 3'(deglitch_cycles)) begin
        state_d = seq_pll_rst; seq_cnt_d = 16'h0000; end
      seq_pll_rst: if (seq_cnt_q == 16'(pll_reset_cycles - 1)) begin
        state_d = seq_lock; seq_cnt_d = 16'h0000; end
      seq_lock:    if (seq_cnt_q == 16'(lock_wait_cycles - 1)) begin
        state_d = seq_settle; seq_cnt_d = 16'h0000; end
      seq_settle:  if (seq_cnt_q == 16'(settle_count - 1)) begin
        state_d = seq_clocks; seq_cnt_d = 16'h0000; end
      seq_clocks:  if (seq_cnt_q == 16'(output_wait_cycles - 1)) begin
        state_d = seq_run; seq_cnt_d = 16'h0000; end
      seq_run:     seq_cnt_d = 16'h0000;
      default:     begin state_d = seq_filter; seq_cnt_d = 16'h0000; end
    endcase
    if (!por_s2_q) begin
      state_d   = seq_filter;
      seq_cnt_d = 16'h0000;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      por_s1_q  <= 1'b0;
      por_s2_q  <= 1'b0;
      filt_q    <= 3'h0;
      state_q   <= seq_filter;
      seq_cnt_q <= 16'h0000;
    end else begin
      por_s1_q  <= i_power_on_resetn;
      por_s2_q  <= por_s1_q;
      filt_q    <= filt_d;
      state_q   <= state_d;
      seq_cnt_q <= seq_cnt_d;
    end
  end

  assign o_pll_resetn  = !(state_q == seq_filter || state_q == seq_pll_rst);
  assign o_chip_resetn = (state_q == seq_clocks || state_q == seq_run);
  assign o_pre_resetn  = (state_q == seq_run) && o_global_resetn_one && o_global_resetn_two;

  // ---------------------------------------------------------------------------
  // keyed global software resets
  // ---------------------------------------------------------------------------
  logic [15:0] hold_cnt_q, hold_cnt_d;
  logic        glb1_q, glb1_d, glb2_q, glb2_d;
  always_comb begin
    glb1_d     = glb1_q | key_one_hit;
    glb2_d     = glb2_q | key_two_hit;
    hold_cnt_d = (glb1_q | glb2_q) ? hold_cnt_q + 16'h0001 : 16'h0000;
    if ((glb1_q | glb2_q) && (hold_cnt_q >= hold_q || hold_cnt_q == 16'(hold_limit - 1))) begin
      glb1_d     = key_one_hit;
      glb2_d     = key_two_hit;
      hold_cnt_d = 16'h0000;
    end
  end
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      glb1_q     <= 1'b0;
      glb2_q     <= 1'b0;
      hold_cnt_q <= 16'h0000;
    end else begin
      glb1_q     <= glb1_d;
      glb2_q     <= glb2_d;
      hold_cnt_q <= hold_cnt_d;
    end
  end
  assign o_global_resetn_one    = !glb1_q;
  assign o_global_resetn_two    = !glb2_q;
  assign o_register_file_resetn = !glb1_q;

  // ---------------------------------------------------------------------------
  // glitch-free clock gates, enable latched while source is low
  // ---------------------------------------------------------------------------
  logic [31:0] gate_bits;
  assign gate_bits = {gate1_q, gate0_q};
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : gen_gate
      logic run_l;
      always_latch begin
        if (!i_source_clocks[g]) run_l = !gate_bits[g];
      end
      assign o_gated_clocks[g] = i_source_clocks[g] & run_l;
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // dividers
  // ---------------------------------------------------------------------------
  pmu_clock_divider u_divider (
    .i_clock     (i_clock),
    .i_resetn    (i_resetn),
    .i_div_value (divcfg_q),
    .o_half_duty (o_half_duty_clock),
    .o_half_step (o_half_step_clock)
  );

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  a_pll_reset_hold: assert property ($rose(o_pll_resetn) |->
                                     $past(seq_cnt_q) == 16'(pll_reset_cycles - 1))
    else $error("pll reset released early");
  a_chip_after_pll: assert property ($rose(o_chip_resetn) |-> o_pll_resetn)
    else $error("chip reset before pll reset");
  a_pre_after_chip: assert property ($rose(o_pre_resetn) |-> o_chip_resetn)
    else $error("pre reset before chip reset");
  a_lock_needs_both: assert property (lock_status |-> i_analog_lock && lock_cnt_q == thresh_q)
    else $error("lock without both sources");
  a_slip_clears: assert property (i_cycle_slip |=> !lock_status)
    else $error("lock held after slip");
  a_key_one_fires: assert property (key_one_hit |=> !o_global_resetn_one)
    else $error("key one ignored");
  a_key_two_fires: assert property (key_two_hit |=> !o_global_resetn_two)
    else $error("key two ignored");
  a_reset_release: assert property ($fell(o_global_resetn_one) |-> ##[1:1000] o_global_resetn_one || hold_q > 16'd999)
    else $error("global reset stuck");
  a_mask_write: assert property (i_write && i_address == clock_gate_ctrl0_offset && i_write_data[16] == 1'b0
                                 |=> gate0_q[0] == $past(gate0_q[0]))
    else $error("unmasked gate bit changed");
endmodule : pmu_clock_reset_unit

//--- sim/pmu_pll_partner.sv
`timescale 1ns/1ps
module pmu_pll_partner #(
  parameter int lock_delay = 100
) (
  input  wire logic   i_clock,
  input  wire logic   i_pll_resetn,
  input  wire logic   i_power_down,
  input  wire logic   i_slip,
  output logic        o_power_on_resetn,
  output logic        o_analog_lock,
  output logic        o_cycle_slip,
  output logic [31:0] o_source_clocks
);
  int   count_q = 0;
  logic src_q   = 1'b0;
  initial begin
    o_power_on_resetn = 1'b0;
    #400 o_power_on_resetn = 1'b1;
    // two-cycle glitch before the real release
    #50 o_power_on_resetn = 1'b0;
    #300 o_power_on_resetn = 1'b1;
  end
  always @(posedge i_clock) begin
    src_q <= ~src_q;
    if (!i_pll_resetn || i_power_down || i_slip) begin
      count_q <= 0;
    end else if (count_q < lock_delay + 256) begin
      count_q <= count_q + 1;
    end
  end
  assign o_analog_lock   = (count_q == lock_delay + 256) && !i_power_down;
  assign o_cycle_slip    = i_slip;
  assign o_source_clocks = {32{src_q}};
endmodule : pmu_pll_partner

//--- sim/pmu_clock_reset_unit_tb.sv
`timescale 1ns/1ps
module pmu_clock_reset_unit_tb;
  import pmu_cru_pkg::*;
  logic        i_clock = 1'b0, i_resetn = 1'b0, wr = 1'b0, rd = 1'b0, slip = 1'b0;
  logic        por, lock, cslip, pllr, chipr, prer, pd, byp, moff, g1, g2, rf, hd, hs;
  logic [15:0] adr = 16'h0000;
  logic [31:0] wd = 32'h0000_0000, rdata, gated, src, v;
  logic [2:0]  d1, d2;
  logic [5:0]  refd;
  logic [11:0] fbd;
  logic [23:0] frac;
  int          errors = 0, n_checks = 0, cyc = 0, t_por, t_pll, t_chip, t_pre, k, t0, n[3];
  real         hd_e, hs_e, hs_p, hs_s, hd_w[2];
  pmu_clock_reset_unit #(.settle_count(20), .hold_limit(50)) pmu_clock_reset_unit_i (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_power_on_resetn(por), .i_address(adr),
    .i_write_data(wd), .i_write(wr), .i_read(rd), .i_analog_lock(lock), .i_cycle_slip(cslip),
    .i_source_clocks(src), .o_read_data(rdata), .o_gated_clocks(gated), .o_pll_resetn(pllr),
    .o_chip_resetn(chipr), .o_pre_resetn(prer), .o_loop_power_down(pd), .o_bypass(byp),
    .o_modulator_off(moff), .o_output_divider_one(d1), .o_output_divider_two(d2),
    .o_reference_divider(refd), .o_feedback_divider(fbd), .o_fraction(frac),
    .o_global_resetn_one(g1), .o_global_resetn_two(g2), .o_register_file_resetn(rf),
    .o_half_duty_clock(hd), .o_half_step_clock(hs));
  pmu_pll_partner pmu_pll_partner_i (.i_clock(i_clock), .i_pll_resetn(pllr), .i_power_down(pd),
    .i_slip(slip), .o_power_on_resetn(por), .o_analog_lock(lock), .o_cycle_slip(cslip),
    .o_source_clocks(src));
  always #12.5 i_clock = ~i_clock;
  always @(negedge i_clock) cyc <= cyc + 1;
  always @(posedge por) t_por = cyc;
  always @(posedge pllr) t_pll = cyc;
  always @(posedge chipr) t_chip = cyc;
  always @(posedge prer) t_pre = cyc;
  always @(hd) begin
    hd_w[hd] = $realtime - hd_e;
    hd_e = $realtime;
  end
  always @(posedge hs) begin
    hs_s = $realtime - hs_p;
    hs_p = hs_e;
    hs_e = $realtime;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  function automatic logic [31:0] inr(input int x, input int lo, input int hi);
    return {31'h0, x >= lo && x <= hi};
  endfunction : inr
  task automatic wr32(input logic [15:0] a, input logic [31:0] d);
    @(posedge i_clock);
    adr <= a;
    wd  <= d;
    wr  <= 1'b1;
    @(posedge i_clock);
    wr  <= 1'b0;
  endtask : wr32
  task automatic rd32(input logic [15:0] a, output logic [31:0] d);
    @(posedge i_clock);
    adr <= a;
    rd  <= 1'b1;
    @(posedge i_clock);
    rd  <= 1'b0;
    #1 d = rdata;
  endtask : rd32
  task automatic keyed(input logic [15:0] a, input logic [15:0] key);
    n = '{0, 0, 0};
    wr32(reset_hold_offset, 32'h0000_000a);
    wr32(a, {16'h0000, key});
    repeat (60) begin
      @(negedge i_clock);
      n[0] += int'(g1 === 1'b0);
      n[1] += int'(g2 === 1'b0);
      n[2] += int'(rf === 1'b0);
    end
  endtask : keyed
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  task automatic bail(input logic ok);
    if (ok !== 1'b1) begin
      errors++;
      tally_and_finish;
    end
  endtask : bail
  initial begin
    repeat (8) @(posedge i_clock);
    i_resetn <= 1'b1;
    rd32(pll_ctrl0_offset, v);
    chk("ctrl0 reset", v, {16'h0000, pll_ctrl0_reset});
    rd32(pll_ctrl1_offset, v);
    chk("ctrl1 reset", v, {16'h0000, pll_ctrl1_reset});
    rd32(lock_threshold_offset, v);
    chk("threshold reset", v, {lock_threshold_reset, 16'h0000});
    rd32(16'hc0fc, v);
    chk("unmapped", v, 32'h0000_0000);
    rd32(clock_gate_ctrl0_offset, v);
    chk("gate reset", v, 32'h0000_0000);
    wr32(clock_gate_ctrl0_offset, 32'h0001_0003);
    rd32(clock_gate_ctrl0_offset, v);
    chk("gate mask", v, 32'h0000_0001);
    for (k = 0; k < 4; k++) begin
      @(negedge i_clock);
      chk("gated pair", {30'h0, gated[1:0]}, {30'h0, src[1], 1'b0});
    end
    wr32(clock_gate_ctrl1_offset, 32'hffff_ffff);
    rd32(clock_gate_ctrl1_offset, v);
    chk("gate1 mask", v, {16'h0000, gate1_writable});
    @(negedge i_clock);
    chk("gate1 stops", {27'h0, gated[20:16]}, 32'h0);
    for (k = 0; k < 5000 && prer !== 1'b1; k++) @(posedge i_clock);
    bail(prer);
    chk("pll hold", inr(t_pll - t_por, pll_reset_cycles, pll_reset_cycles + 8), 32'h1);
    chk("chip release", inr(t_chip - t_pll, 20, 20 + lock_wait_cycles + 4), 32'h1);
    chk("pre release", inr(t_pre - t_chip, output_wait_cycles, output_wait_cycles + 2), 32'h1);
    rd32(pll_ctrl1_offset, v);
    chk("lock on", {31'h0, v[lock_bit]}, 32'h1);
    @(posedge i_clock);
    slip <= 1'b1;
    @(posedge i_clock);
    slip <= 1'b0;
    t0 = cyc;
    rd32(pll_ctrl1_offset, v);
    chk("lock off", {31'h0, v[lock_bit]}, 32'h0);
    for (k = 0; k < 500 && v[lock_bit] !== 1'b1; k++) rd32(pll_ctrl1_offset, v);
    bail(v[lock_bit]);
    chk("relock", inr(cyc - t0, 356, 356 + max_lock_delay + 8), 32'h1);
    wr32(pll_ctrl0_offset, 32'hffff_a0af);
    wr32(pll_ctrl1_offset, 32'hffff_00c6);
    wr32(pll_ctrl2_offset, 32'h00f5_c28f);
    #1 chk("ctrl0 fields", {16'h0000, byp, d1, fbd}, 32'h0000_a0af);
    chk("ctrl1 fields", {19'h0, moff, 3'h0, d2, refd}, 32'h0000_00c6);
    chk("fraction", {8'h00, frac}, 32'h00f5_c28f);
    wr32(pll_ctrl1_offset, 32'h8000_8000);
    wr32(pll_ctrl1_offset, 32'h2000_2000);
    #1 chk("pd0 ignored", {31'h0, pd}, 32'h0);
    wr32(pll_ctrl1_offset, 32'h4000_4000);
    #1 chk("pd1", {31'h0, pd}, 32'h1);
    rd32(pll_ctrl1_offset, v);
    chk("lock lost", {31'h0, v[lock_bit]}, 32'h0);
    wr32(pll_ctrl1_offset, 32'he000_0000);
    wr32(pll_ctrl1_offset, 32'h2000_2000);
    #1 chk("pd0", {31'h0, pd}, 32'h1);
    wr32(pll_ctrl1_offset, 32'h2000_0000);
    wr32(divider_ctrl_offset, 32'h0000_0002);
    repeat (40) @(posedge i_clock);
    chk("half step", 32'(int'(hs_s)), 32'd125);
    chk("half duty", 32'(int'(hd_w[0])), 32'(int'(hd_w[1])));
    chk("half duty period", 32'(int'(hd_w[0] + hd_w[1])), 32'd75);
    keyed(reset_key_one_offset, 16'h1234);
    chk("wrong key", 32'(n[0] + n[1]), 32'h0);
    keyed(reset_key_two_offset, key_two_value);
    chk("hold two", inr(n[1], 10, 12), 32'h1);
    chk("files kept", 32'(n[2]), 32'h0);
    keyed(reset_key_one_offset, key_one_value);
    chk("hold one", inr(n[0], 10, 12), 32'h1);
    chk("files hit", {31'h0, n[2] > 0}, 32'h1);
    tally_and_finish;
  end
endmodule : pmu_clock_reset_unit_tb
